// file: core/edsi_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and carriers for the dma status interrupt enable block
// ----------------------------------------------------------------------------
package edsi_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS_FLAGS = 12'h004;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS_FLAGS = 32'h0000_0000;
  // implemented bits; 31..25, 23, 15..13 and 6 stay zero
  localparam logic [31:0] IMPL_BITS = 32'h017F_1FBF;

  // ----------------------------------------------------------------------------
  // bit positions shared by the mask and the status flags
  // ----------------------------------------------------------------------------
  localparam int unsigned BIT_RX_FRAME_COUNTER_OVERFLOW = 24;
  localparam int unsigned BIT_MAC_STATUS_SUMMARY = 22;
  localparam int unsigned BIT_TX_COMPLETE = 21;
  localparam int unsigned BIT_TX_DESCRIPTOR_EXHAUSTED = 20;
  localparam int unsigned BIT_TX_FIFO_UNDERFLOW = 19;
  localparam int unsigned BIT_FRAME_RECEIVED = 18;
  localparam int unsigned BIT_RX_DESCRIPTOR_EXHAUSTED = 17;
  localparam int unsigned BIT_RX_FIFO_OVERFLOW = 16;
  localparam int unsigned BIT_ILLEGAL_TX_FRAME = 12;
  localparam int unsigned BIT_CARRIER_MISSING = 11;
  localparam int unsigned BIT_CARRIER_LOST = 10;
  localparam int unsigned BIT_COLLISION = 9;
  localparam int unsigned BIT_TX_RETRY_OVER = 8;
  localparam int unsigned BIT_RX_MULTICAST = 7;
  localparam int unsigned BIT_RX_DISCARD_REQUEST = 5;
  localparam int unsigned BIT_RX_RESIDUAL_BIT = 4;
  localparam int unsigned BIT_RX_TOO_LONG = 3;
  localparam int unsigned BIT_RX_TOO_SHORT = 2;
  localparam int unsigned BIT_PHY_RX_ERROR = 1;
  localparam int unsigned BIT_RX_CRC_ERROR = 0;

  // ----------------------------------------------------------------------------
  // retry-over counting
  // ----------------------------------------------------------------------------
  localparam logic [4:0] RETRY_TOTAL_FAILS = 5'h10;
  localparam logic [4:0] RETRY_LAST_BEFORE = 5'h0F;
  localparam logic [4:0] RST_RETRY_COUNT = 5'h00;

  // ----------------------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } edsi_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } edsi_axi_rsp_s;

endpackage

// file: core/edsi_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - mask bit one enables, zero blocks source
// - all enable bits clear after reset
// - reserved mask bits read zero always
// - bit 24 gates frame counter overflow
// - bit 22 gates mac status summary
// - bit 21 gates transmit complete
// - bit 20 gates transmit descriptor exhausted
// - bit 19 gates transmit fifo underflow
// - bit 18 gates frame received
// - bit 17 gates receive descriptor exhausted
// - bit 16 gates receive fifo overflow
// - bit 12 gates illegal transmit frame
// - bits 11, 10 gate carrier missing, lost
// - bit 9 gates collision detected
// - bit 8 gates transmit retry over
// - bit 7 gates multicast frame received
// - bit 5 gates unhonoured discard request
// - bit 4 gates residual bit frame
// - bits 3, 2 gate too long, short
// - bit 1 gates phy receive error
// - bit 0 gates receive crc error
// - frame received flag set per updated frame
// - retry over after sixteen failed attempts
module edsi_top
  import edsi_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire edsi_axi_req_s axi_req_i,
  output edsi_axi_rsp_s axi_rsp_o,
  input wire logic [31:0] status_evt_i,
  input wire logic rx_frame_done_i,
  input wire logic rx_desc_updated_i,
  input wire logic tx_start_i,
  input wire logic tx_attempt_fail_i,
  output logic irq_o
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [4:0] retry_cnt_q;
  logic [4:0] retry_cnt_d;
  logic irq_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------------------
  // write channel decode
  // ----------------------------------------------------------------------------
  wire logic aw_take = axi_req_i.awvalid & ~aw_held_q;
  wire logic w_take = axi_req_i.wvalid & ~w_held_q;
  // the response slot must be free, so a second write waits for bready
  wire logic do_write = aw_held_q & w_held_q & ~bvalid_q;
  wire logic wr_mask_sel = (awaddr_q == OFS_IRQ_MASK);
  wire logic wr_flags_sel = (awaddr_q == OFS_STATUS_FLAGS);
  wire logic [31:0] wr_lanes = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic mask_wr = do_write & wr_mask_sel;
  // status flags are write-one-to-clear
  wire logic [31:0] flags_clr = (do_write & wr_flags_sel) ? (wdata_q & wr_lanes) : 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // read channel decode
  // ----------------------------------------------------------------------------
  wire logic ar_take = axi_req_i.arvalid & ~rvalid_q;
  wire logic rd_mask_sel = (axi_req_i.araddr == OFS_IRQ_MASK);
  wire logic rd_flags_sel = (axi_req_i.araddr == OFS_STATUS_FLAGS);
  wire logic [31:0] rd_word = rd_mask_sel ? mask_q : (rd_flags_sel ? flags_q : 32'h0000_0000);

  // ----------------------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------------------
  // byte lanes merge, unimplemented bits forced to zero
  assign mask_d = mask_wr ? (((wdata_q & wr_lanes) | (mask_q & ~wr_lanes)) & IMPL_BITS) : mask_q;

  // ----------------------------------------------------------------------------
  // named enables, one per source
  // ----------------------------------------------------------------------------
  wire logic rx_frame_counter_overflow_en = mask_q[BIT_RX_FRAME_COUNTER_OVERFLOW];
  wire logic mac_status_summary_en = mask_q[BIT_MAC_STATUS_SUMMARY];
  wire logic tx_complete_en = mask_q[BIT_TX_COMPLETE];
  wire logic tx_descriptor_exhausted_en = mask_q[BIT_TX_DESCRIPTOR_EXHAUSTED];
  wire logic tx_fifo_underflow_en = mask_q[BIT_TX_FIFO_UNDERFLOW];
  wire logic frame_received_en = mask_q[BIT_FRAME_RECEIVED];
  wire logic rx_descriptor_exhausted_en = mask_q[BIT_RX_DESCRIPTOR_EXHAUSTED];
  wire logic rx_fifo_overflow_en = mask_q[BIT_RX_FIFO_OVERFLOW];
  wire logic illegal_tx_frame_en = mask_q[BIT_ILLEGAL_TX_FRAME];
  wire logic carrier_missing_en = mask_q[BIT_CARRIER_MISSING];
  wire logic carrier_lost_en = mask_q[BIT_CARRIER_LOST];
  wire logic collision_en = mask_q[BIT_COLLISION];
  wire logic tx_retry_over_en = mask_q[BIT_TX_RETRY_OVER];
  wire logic rx_multicast_en = mask_q[BIT_RX_MULTICAST];
  wire logic rx_discard_request_en = mask_q[BIT_RX_DISCARD_REQUEST];
  wire logic rx_residual_bit_en = mask_q[BIT_RX_RESIDUAL_BIT];
  wire logic rx_too_long_en = mask_q[BIT_RX_TOO_LONG];
  wire logic rx_too_short_en = mask_q[BIT_RX_TOO_SHORT];
  wire logic phy_rx_error_en = mask_q[BIT_PHY_RX_ERROR];
  wire logic rx_crc_error_en = mask_q[BIT_RX_CRC_ERROR];

  // gather the enables back into a vector; unlisted bits stay zero
  logic [31:0] en_vec;
  always_comb begin
    en_vec = 32'h0000_0000;
    en_vec[BIT_RX_FRAME_COUNTER_OVERFLOW] = rx_frame_counter_overflow_en;
    en_vec[BIT_MAC_STATUS_SUMMARY] = mac_status_summary_en;
    en_vec[BIT_TX_COMPLETE] = tx_complete_en;
    en_vec[BIT_TX_DESCRIPTOR_EXHAUSTED] = tx_descriptor_exhausted_en;
    en_vec[BIT_TX_FIFO_UNDERFLOW] = tx_fifo_underflow_en;
    en_vec[BIT_FRAME_RECEIVED] = frame_received_en;
    en_vec[BIT_RX_DESCRIPTOR_EXHAUSTED] = rx_descriptor_exhausted_en;
    en_vec[BIT_RX_FIFO_OVERFLOW] = rx_fifo_overflow_en;
    en_vec[BIT_ILLEGAL_TX_FRAME] = illegal_tx_frame_en;
    en_vec[BIT_CARRIER_MISSING] = carrier_missing_en;
    en_vec[BIT_CARRIER_LOST] = carrier_lost_en;
    en_vec[BIT_COLLISION] = collision_en;
    en_vec[BIT_TX_RETRY_OVER] = tx_retry_over_en;
    en_vec[BIT_RX_MULTICAST] = rx_multicast_en;
    en_vec[BIT_RX_DISCARD_REQUEST] = rx_discard_request_en;
    en_vec[BIT_RX_RESIDUAL_BIT] = rx_residual_bit_en;
    en_vec[BIT_RX_TOO_LONG] = rx_too_long_en;
    en_vec[BIT_RX_TOO_SHORT] = rx_too_short_en;
    en_vec[BIT_PHY_RX_ERROR] = phy_rx_error_en;
    en_vec[BIT_RX_CRC_ERROR] = rx_crc_error_en;
  end

  // one reduction feeds both the request flop and its check
  wire logic irq_any = |(flags_q & en_vec);

  // ----------------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------------
  // frame received counts only once the descriptor is written back
  wire logic frame_received_evt = rx_frame_done_i & rx_desc_updated_i;
  // sixteenth failure in a row; a new transmission restarts the count
  wire logic retry_over_evt = tx_attempt_fail_i & ~tx_start_i & (retry_cnt_q == RETRY_LAST_BEFORE);
  assign retry_cnt_d = tx_start_i ? RST_RETRY_COUNT :
                       (retry_over_evt ? RST_RETRY_COUNT :
                       (tx_attempt_fail_i ? retry_cnt_q + 5'h01 : retry_cnt_q));

  logic [31:0] flags_set;
  always_comb begin
    flags_set = status_evt_i & IMPL_BITS;
    flags_set[BIT_FRAME_RECEIVED] = frame_received_evt;
    flags_set[BIT_TX_RETRY_OVER] = retry_over_evt;
  end

  // a set in the cycle of its clear wins; mask writes never reach here
  assign flags_d = (flags_q & ~flags_clr) | flags_set;

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // mask, flags, retry count and request flop
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= RST_IRQ_MASK;
      flags_q <= RST_STATUS_FLAGS;
      retry_cnt_q <= RST_RETRY_COUNT;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      flags_q <= flags_d;
      retry_cnt_q <= retry_cnt_d;
      irq_q <= irq_any;
    end
  end

  // write address and data are caught independently
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_held_q <= do_write ? 1'b0 : (aw_held_q | aw_take);
      w_held_q <= do_write ? 1'b0 : (w_held_q | w_take);
      if (aw_take) begin
        awaddr_q <= axi_req_i.awaddr;
      end
      if (w_take) begin
        wdata_q <= axi_req_i.wdata;
        wstrb_q <= axi_req_i.wstrb;
      end
    end
  end

  // write response and read data
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_mask_sel | wr_flags_sel) ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_i.bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_mask_sel | rd_flags_sel) ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_i.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // readies are combinational so a held channel is refused at once
  assign axi_rsp_o.awready = ~aw_held_q;
  assign axi_rsp_o.wready = ~w_held_q;
  assign axi_rsp_o.bvalid = bvalid_q;
  assign axi_rsp_o.bresp = bresp_q;
  assign axi_rsp_o.arready = ~rvalid_q;
  assign axi_rsp_o.rvalid = rvalid_q;
  assign axi_rsp_o.rdata = rdata_q;
  assign axi_rsp_o.rresp = rresp_q;
  assign irq_o = irq_q;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // marks the first edge after reset release
  logic seen_edge_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_edge_q <= 1'b0;
    end else begin
      seen_edge_q <= 1'b1;
    end
  end

  AST_MASK_RESET: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !seen_edge_q |-> (mask_q == 32'h0000_0000) && !irq_o)
    else $error("mask not clear after reset");

  AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ar_take && rd_mask_sel |=> (axi_rsp_o.rdata & ~IMPL_BITS) == 32'h0000_0000)
    else $error("reserved mask bits read nonzero");

  AST_MASK_WRITE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mask_wr && wstrb_q == 4'hF |=> mask_q == ($past(wdata_q) & IMPL_BITS))
    else $error("mask write not stored");

  AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ##1 irq_o == $past(irq_any))
    else $error("request does not follow enabled flags");

  AST_MASKED_QUIET: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (mask_q == 32'h0000_0000) [*2] |-> !irq_o)
    else $error("request raised with all sources disabled");

  AST_FRAME_FLAG: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    frame_received_evt |=> flags_q[BIT_FRAME_RECEIVED] ##1 (irq_o || !$past(frame_received_en)))
    else $error("frame received flag or request missing");

  AST_RETRY_OVER: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_attempt_fail_i && !tx_start_i && retry_cnt_q == RETRY_LAST_BEFORE |=> flags_q[BIT_TX_RETRY_OVER]
      && retry_cnt_q == RST_RETRY_COUNT)
    else $error("retry over not raised on sixteenth failure");

  AST_RETRY_EARLY: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    retry_cnt_q < RETRY_LAST_BEFORE |-> !retry_over_evt)
    else $error("retry over raised too early");

  AST_MASK_KEEPS_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mask_wr && flags_set == 32'h0000_0000 |=> flags_q == $past(flags_q))
    else $error("mask write disturbed status flags");

  AST_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (flags_set & flags_clr) != 32'h0000_0000 |=> (flags_q & $past(flags_set)) == $past(flags_set))
    else $error("clear beat a simultaneous set");

  AST_BVALID_HOLD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bvalid_q && !axi_req_i.bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before bready");

  // ----------------------------------------------------------------------------
  // bus channel, register and counter checks
  // ----------------------------------------------------------------------------
  // a held channel must refuse, or a second request would overwrite the first
  AST_RVALID_HOLD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rvalid_q && !axi_req_i.rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read data dropped before rready");

  AST_AR_REFUSED: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rvalid_q |-> !axi_rsp_o.arready)
    else $error("read address accepted while data stands");

  AST_AW_REFUSED: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    aw_held_q |-> !axi_rsp_o.awready)
    else $error("write address accepted while one is held");

  AST_BRESP_MAPPED: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    do_write && wr_mask_sel |=> bvalid_q && bresp_q == RESP_OKAY)
    else $error("mask write not answered okay");

  AST_READ_MASK: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ar_take && rd_mask_sel |=> axi_rsp_o.rdata == $past(mask_q))
    else $error("mask read returned a stale word");

  AST_MASK_NO_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (mask_q & ~IMPL_BITS) == 32'h0000_0000)
    else $error("reserved mask bit held a one");

  AST_FLAGS_NO_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (flags_q & ~IMPL_BITS) == 32'h0000_0000)
    else $error("reserved flag bit held a one");

  AST_MASK_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !mask_wr |=> mask_q == $past(mask_q))
    else $error("mask changed without a write");

  // a flag that silently dropped would lose an event that software never saw
  AST_FLAGS_STICKY: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ##1 ($past(flags_q) & ~$past(flags_clr) & ~flags_q) == 32'h0000_0000)
    else $error("status flag lost without a clear");

  AST_FLAGS_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (flags_clr & ~flags_set) != 32'h0000_0000
      |=> (flags_q & $past(flags_clr) & ~$past(flags_set)) == 32'h0000_0000)
    else $error("written one did not clear its flag");

  AST_FRAME_NEEDS_DESC: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rx_frame_done_i && !rx_desc_updated_i && !flags_q[BIT_FRAME_RECEIVED] |=> !flags_q[BIT_FRAME_RECEIVED])
    else $error("frame flag set before descriptor update");

  AST_RETRY_COUNTS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_attempt_fail_i && !tx_start_i && retry_cnt_q < RETRY_LAST_BEFORE
      |=> retry_cnt_q == $past(retry_cnt_q) + 5'h01)
    else $error("failed attempt not counted");

  AST_RETRY_RESTART: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_start_i |=> retry_cnt_q == RST_RETRY_COUNT)
    else $error("new transmission did not restart the count");

  // ----------------------------------------------------------------------------
  // per-source gate checks
  // ----------------------------------------------------------------------------
  // reserved positions have no flag, so they get no pair of checks
  for (genvar g = 0; g < 32; g++) begin : g_gate_chk
    if (IMPL_BITS[g]) begin : g_impl
      AST_GATE_PASSES: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        flags_q[g] && mask_q[g] |=> irq_o)
        else $error("enabled flag did not raise the request");

      AST_GATE_BLOCKS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        flags_q == (32'h0000_0001 << g) && !mask_q[g] |=> !irq_o)
        else $error("lone disabled flag raised the request");
    end
  end

endmodule // edsi_top

// file: tb/edsi_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// compare helper: counts every check, reports a mismatch at once
// ----------------------------------------------------------------------------
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
  import edsi_pkg::*;

  // ----------------------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  edsi_axi_req_s axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
  edsi_axi_rsp_s axi_rsp;
  logic [31:0] status_evt_i = 32'h0000_0000;
  logic rx_frame_done_i = 1'b0;
  logic rx_desc_updated_i = 1'b0;
  logic tx_start_i = 1'b0;
  logic tx_attempt_fail_i = 1'b0;
  logic irq_o;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  edsi_top i_dut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .axi_req_i(axi_req),
    .axi_rsp_o(axi_rsp),
    .status_evt_i(status_evt_i),
    .rx_frame_done_i(rx_frame_done_i),
    .rx_desc_updated_i(rx_desc_updated_i),
    .tx_start_i(tx_start_i),
    .tx_attempt_fail_i(tx_attempt_fail_i),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------------------
  // bus master: handshake values are read at the edge, before that edge's updates land
  // ----------------------------------------------------------------------------
  // no cycle limit in the waits: only the watchdog ends a hung transfer
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= s;
    axi_req.wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    `CHK("write readies with response", 2'b11, {axi_rsp.awready, axi_rsp.wready})
    rs = axi_rsp.bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    `CHK("arready while read data stands", 1'b0, axi_rsp.arready)
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
  endtask

  // one-cycle event pulse; irq is visible two edges later, read at the third
  task automatic evt(input logic [31:0] v);
    status_evt_i <= v;
    @(posedge clk_sys_i);
    status_evt_i <= 32'h0000_0000;
    repeat (2) @(posedge clk_sys_i);
  endtask

  // sel: 0 frame done, 1 transmission start, 2 failed attempt
  task automatic pulse(input int sel, input int gap);
    if (sel == 0) rx_frame_done_i <= 1'b1;
    else if (sel == 1) tx_start_i <= 1'b1;
    else tx_attempt_fail_i <= 1'b1;
    @(posedge clk_sys_i);
    if (sel == 0) rx_frame_done_i <= 1'b0;
    else if (sel == 1) tx_start_i <= 1'b0;
    else tx_attempt_fail_i <= 1'b0;
    repeat (gap) @(posedge clk_sys_i);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    axi_rd(OFS_IRQ_MASK);
    `CHK("mask after reset", 32'h0000_0000, rd)
    `CHK("mask read resp", RESP_OKAY, rs)
    axi_rd(OFS_STATUS_FLAGS);
    `CHK("flags after reset", 32'h0000_0000, rd)
    `CHK("irq after reset", 1'b0, irq_o)
  endtask

  // reserved bits are written as zero, as software must; partial strobes touch only their lanes
  task automatic t_reserved;
    axi_wr(OFS_IRQ_MASK, 32'h017F_1FBF, 4'hF);
    axi_rd(OFS_IRQ_MASK);
    `CHK("mask reserved bits", 32'h017F_1FBF, rd)
    axi_wr(OFS_IRQ_MASK, 32'h0000_0000, 4'h1);
    axi_wr(OFS_IRQ_MASK, 32'h0000_0000, 4'h4);
    axi_rd(OFS_IRQ_MASK);
    `CHK("mask byte lanes", 32'h0100_1F00, rd)
    axi_wr(OFS_IRQ_MASK, 32'h0000_0000, 4'hF);
  endtask

  task automatic t_unmapped;
    axi_wr(12'h008, 32'hFFFF_FFFF, 4'hF);
    `CHK("unmapped write resp", RESP_SLVERR, rs)
    axi_rd(12'h008);
    `CHK("unmapped read data", 32'h0000_0000, rd)
    `CHK("unmapped read resp", RESP_SLVERR, rs)
    axi_rd(OFS_IRQ_MASK);
    `CHK("mask after unmapped write", 32'h0000_0000, rd)
  endtask

  // each source alone except bits 8 and 18: blocked by its own bit only, passed by its own bit
  task automatic t_gates;
    logic [31:0] m;
    int b;
    for (b = 0; b < 32; b++) begin
      m = 32'h0000_0001 << b;
      if (((32'h017F_1FBF & m) != 32'h0) && b != 8 && b != 18) begin
        axi_wr(OFS_IRQ_MASK, 32'h017F_1FBF & ~m, 4'hF);
        evt(m);
        `CHK("irq from masked source", 1'b0, irq_o)
        axi_wr(OFS_IRQ_MASK, m, 4'hF);
        axi_rd(OFS_STATUS_FLAGS);
        `CHK("flag kept across mask write", m, rd)
        `CHK("irq from enabled source", 1'b1, irq_o)
        axi_wr(OFS_STATUS_FLAGS, m, 4'hF);
        @(posedge clk_sys_i);
        `CHK("irq after flag clear", 1'b0, irq_o)
      end
    end
  endtask

  task automatic t_frame;
    axi_wr(OFS_IRQ_MASK, 32'h0004_0000, 4'hF);
    pulse(0, 2);
    `CHK("frame without descriptor update", 1'b0, irq_o)
    rx_desc_updated_i <= 1'b1;
    pulse(0, 0);
    rx_desc_updated_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    `CHK("frame received irq", 1'b1, irq_o)
    axi_rd(OFS_STATUS_FLAGS);
    `CHK("frame received flag", 32'h0004_0000, rd)
    axi_wr(OFS_STATUS_FLAGS, 32'h0004_0000, 4'hF);
  endtask

  // a new transmission restarts the count of failed attempts
  task automatic t_retry;
    axi_wr(OFS_IRQ_MASK, 32'h0000_0100, 4'hF);
    pulse(1, 0);
    repeat (8) pulse(2, 1);
    pulse(1, 0);
    repeat (15) pulse(2, 1);
    @(posedge clk_sys_i);
    `CHK("retry over after 15 fails", 1'b0, irq_o)
    pulse(2, 2);
    `CHK("retry over after 16 fails", 1'b1, irq_o)
    axi_wr(OFS_STATUS_FLAGS, 32'h0000_0100, 4'hF);
  endtask

  // a second reset in mid-run must drop the request and the whole mask
  task automatic t_rerun;
    axi_wr(OFS_IRQ_MASK, 32'h017F_1FBF, 4'hF);
    evt(32'h0000_0001);
    `CHK("irq before reset", 1'b1, irq_o)
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    `CHK("irq during reset", 1'b0, irq_o)
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    axi_rd(OFS_IRQ_MASK);
    `CHK("mask after second reset", 32'h0000_0000, rd)
    axi_rd(OFS_STATUS_FLAGS);
    `CHK("flags after second reset", 32'h0000_0000, rd)
  endtask

  // ----------------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // responses are always accepted, so bready and rready simply stay high
  initial begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_reserved();
    t_unmapped();
    t_gates();
    t_frame();
    t_retry();
    t_rerun();
    final_report();
  end

  // the tests need well under a thousand cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report();
  end
endmodule // testbench
